//--- dv/bct_mcu_model.sv
// Far-side controller model: drives the bridge control pins and
// resolves the open-drain error line with its pull-up.
// Assumes the bench calls set_pins just after a rising clock edge.
`default_nettype none
module bct_mcu_model (
	input  wire logic  i_core_clk,
	input  wire logic  i_err_oe_n,
	input  wire logic  i_err_out,
	output logic       o_err_line,
	output logic       o_in1,
	output logic       o_in2,
	output logic       o_low_power_request_n,
	output logic [2:0] o_trip_pin,
	output logic [2:0] o_load_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// The line has a pull-up, so a released pin reads high, not old data.
	assign o_err_line = i_err_oe_n ? 1'b1 : i_err_out;
	// Inputs idle low
	// Inputs idle low and awake, so no load check starts by accident.
	initial begin
		o_in1 = 1'b0;
		o_in2 = 1'b0;
		o_low_power_request_n = 1'b1;
		o_trip_pin = 3'h1;
		o_load_pin = 3'h3;
	end
	// All pins change together after one edge and hold until the next call.
	task automatic set_pins(input logic a, b, w, input logic [2:0] t, l);
		@(posedge i_core_clk);
		o_in1 <= a;
		o_in2 <= b;
		o_low_power_request_n <= w;
		o_trip_pin <= t;
		o_load_pin <= l;
	endtask : set_pins
endmodule : bct_mcu_model
`default_nettype wire

//--- dv/bridge_current_trip_load_check_select_control_tb_top.sv
// Self-checking bench of the bridge control block with bus tasks.
// Assumes a zero-wait bus slave and shortened off-times of 60 cycles strapped and 40 cycles by register.
`default_nettype none
module bridge_current_trip_load_check_select_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, regv = 0, indep = 0;
	logic trip = 0, slew = 0, ocp = 0, dis = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, r;
	int n_fail = 0, tests_run = 0;
	wire logic hrdy, err_line, in1, in2, wake_n, out1, out2, off_act;
	wire logic pen, act_en, retry, oe_n, pin_out, hresp, bridge_on;
	wire logic [2:0] tpin, lpin, trip_code;
	wire logic [31:0] hrdata;
	logic [2:0] tab[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [2:0] lvl_t[3] = '{3'h1, 3'h5, 3'h3};
	logic [1:0] lod_t[3] = '{2'b01, 2'b00, 2'b10};
	// The clock half period is 5 ns for a 100 MHz core clock.
	always #5 clk = ~clk;
	bct_ctrl #(.CYC_PER_US(2)) u_bct_ctrl (.i_core_clk(clk),
		.i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
		.o_hresp(hresp), .o_hrdata(hrdata), .i_reg_variant(regv),
		.i_indep_mode(indep), .i_in1(in1), .i_in2(in2),
		.i_driver_disable_pin(dis), .i_low_power_request_n(wake_n),
		.i_trip_level_pin(tpin), .i_load_check_select(lpin),
		.i_trip_cmp(trip), .i_slewing(slew), .i_ocp_det(ocp),
		.i_tsd_det(1'b0), .i_ola_det(1'b0),
		.i_passive_check_comparator(1'b0), .i_error_pin_low_in(err_line),
		.o_out1_high(out1), .o_out2_high(out2), .o_bridge_on(bridge_on),
		.o_trip_reference_code(trip_code), .o_passive_check_en(pen),
		.o_active_detect_en(act_en), .o_retry_reaction(retry),
		.o_off_time_active(off_act), .o_error_pin_low_out(pin_out),
		.o_error_pin_low_oe_n(oe_n));
	bct_mcu_model u_bct_mcu_model (.i_core_clk(clk), .i_err_oe_n(oe_n),
		.i_err_out(pin_out), .o_err_line(err_line), .o_in1(in1),
		.o_in2(in2), .o_low_power_request_n(wake_n), .o_trip_pin(tpin),
		.o_load_pin(lpin));
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// A hang is cut short here: a used-up bound is a mismatch and ends the run.
	task automatic give_up();
		n_fail++;
		$display("wrong value at %0t: wait ran out", $time);
		wrap_up();
	endtask : give_up
	// One single word transfer; each phase holds until hready is sampled.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1 && ++k < 20);
		if (k >= 20)
			give_up();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hrdy !== 1'b1 && ++k < 40);
		r = hrdata;
		if (k >= 40)
			give_up();
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(r, exp);
	endtask : rdc
	// Waits on settled values, so it steps on falling edges.
	task automatic wait_for(input logic s, v, input int n);
		int k;
		for (k = 0; k < n && (s ? err_line : off_act) !== v; k++)
			@(negedge clk);
		if (k >= n)
			give_up();
	endtask : wait_for
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(err_line, 1'b1);
		rdc(bct_pkg::OFS_CONFIG, 32'h00000000);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			u_bct_mcu_model.set_pins(0, 0, 1, 3'(i + 1), 3'h3);
			repeat (3) @(negedge clk);
			chk(trip_code, tab[i]);
		end
		$display("test trip levels done");
		u_bct_mcu_model.set_pins(1, 1, 1, 3'h6, 3'h3);
		slew <= 1'b1;
		trip <= 1'b1;
		repeat (150) @(negedge clk);
		chk(off_act, 1'b0);
		@(posedge clk) slew <= 1'b0;
		wait_for(0, 1, 20);
		repeat (2) @(negedge clk);
		chk({bridge_on, out1, out2}, 3'b111);
		repeat (80) @(negedge clk);
		chk(off_act, 1'b1);
		@(posedge clk) trip <= 1'b0;
		repeat (3) @(negedge clk);
		u_bct_mcu_model.set_pins(1, 0, 1, 3'h6, 3'h3);
		wait_for(0, 0, 3);
		$display("test regulation done");
		for (int i = 0; i < 3; i++) begin
			u_bct_mcu_model.set_pins(1, 0, 0, 3'h6, lvl_t[i]);
			u_bct_mcu_model.set_pins(1, 0, 1, 3'h6, lvl_t[i]);
			repeat (4) @(negedge clk);
			chk({pen, retry}, lod_t[i]);
		end
		u_bct_mcu_model.set_pins(1, 0, 1, 3'h6, 3'h1);
		repeat (4) @(negedge clk);
		chk({pen, retry}, 2'b10);
		$display("test load straps done");
		@(posedge clk) regv <= 1'b1;
		indep <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, bct_pkg::OFS_CONFIG, {27'h0, c[1:0], 3'h2});
			repeat (3) @(negedge clk);
			chk(pen, c[0]);
			chk(act_en, c[1]);
			chk(trip_code, c[1] ? 32'h0 : 32'h2);
		end
		@(posedge clk) indep <= 1'b0;
		repeat (2) @(negedge clk);
		chk(pen, 1'b1);
		bus(1'b1, bct_pkg::OFS_CONFIG, 32'h00000002);
		repeat (2) @(negedge clk);
		chk(pen, 1'b0);
		@(posedge clk) trip <= 1'b1;
		wait_for(0, 1, 200);
		chk(err_line, 1'b1);
		rdc(bct_pkg::OFS_ACTIVE, 32'h00000001);
		@(posedge clk) trip <= 1'b0;
		repeat (130) @(negedge clk);
		// Independent halves: the high output must drop low in off-time.
		@(posedge clk) indep <= 1'b1;
		trip <= 1'b1;
		wait_for(0, 1, 200);
		repeat (2) @(negedge clk);
		chk({out1, out2}, 2'b00);
		@(posedge clk) trip <= 1'b0;
		indep <= 1'b0;
		repeat (130) @(negedge clk);
		bus(1'b1, bct_pkg::OFS_COMMAND, 32'h00000001);
		rdc(bct_pkg::OFS_ACTIVE, 32'h00000000);
		$display("test register settings done");
		@(posedge clk) ocp <= 1'b1;
		wait_for(1, 0, 10);
		@(posedge clk) ocp <= 1'b0;
		rdc(bct_pkg::OFS_SUMMARY, 32'h00000001);
		rdc(bct_pkg::OFS_ACTIVE, 32'h00000002);
		repeat (20) @(negedge clk);
		chk(err_line, 1'b0);
		u_bct_mcu_model.set_pins(1, 0, 0, 3'h6, 3'h1);
		wait_for(1, 1, 5);
		u_bct_mcu_model.set_pins(1, 0, 1, 3'h6, 3'h1);
		rdc(bct_pkg::OFS_SUMMARY, 32'h00000000);
		rdc(8'h40, 32'h00000000);
		// Standby with the lock set hands the pin to the passive comparator.
		@(posedge clk) dis <= 1'b1;
		bus(1'b1, bct_pkg::OFS_CONFIG, 32'h00000088);
		wait_for(1, 0, 10);
		rdc(bct_pkg::OFS_STATE, 32'h00000060);
		rdc(bct_pkg::OFS_STANDBY, 32'h00000000);
		chk(hresp, 1'b0);
		bus(1'b1, bct_pkg::OFS_CONFIG, 32'h00000008);
		wait_for(1, 1, 10);
		$display("test error pin done");
		wrap_up();
	end
endmodule : bridge_current_trip_load_check_select_control_tb_top
`default_nettype wire

//--- hdl/bct_ctrl.sv
// Bridge control: fixed off-time current trip regulation, trip level and
// load check decoding, error logging and the open-drain error pin.
// Assumes synchronous control pins, asynchronous analog comparator outputs
// and an AHB-Lite master that issues single word transfers only.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`default_nettype none

// Behaviour
// - Any input change during off-time ends it; outputs follow inputs.
// - Trip comparator is ignored while the outputs are slewing.
// - Extra blanking after leaving low-side recirculation before trip.
// - Trip code 000 disables regulation; straps map to 000,001,100-111.
// - Strapped trip level pin acts immediately, never latched.
// - Register trip level write acts on regulation immediately.
// - Trip reached sets trip flag, no pin; cleared by clear command.
// - High-side load suppresses trip regulation in active state.
// - Low-side load masks active open-load detection.
// - Full-bridge strap: L1 off/retry, L5 off/latch, others on/latch.
// - Independent strap table sets load side, reaction, passive check.
// - Load check strap sampled once at initialisation, then frozen.
// - Register full-bridge load field: 00 passive off, else passive on.
// - Register independent field: bit1 high-side, bit0 passive check.
// - Load check field writes accepted only while awake and act immediately.
// - Any fault pulls the open-drain error pin low, else released.
// - Entering sleep releases the error pin regardless of faults.
// - Register variant pin is inverse summary, except passive override.
// - Every error pin assertion logs its cause in the status registers.
// - Logged bits clear only by clear command or sleep request.
// - One word read of the state's status register gives all faults.
// - Full-bridge trip drives both outputs high for one off-time.
// - Off-time is 30 us strapped, 20 to 50 us by register field.
// - Trip still present at off-time end extends by another off-time.
// - Independent trip forces high outputs low for one off-time.
module bct_ctrl #(
	parameter int CYC_PER_US = bct_pkg::CYC_PER_US_DEF
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [31:0]      o_hrdata,
	input  wire logic        i_reg_variant,
	input  wire logic        i_indep_mode,
	input  wire logic        i_in1,
	input  wire logic        i_in2,
	input  wire logic        i_driver_disable_pin,
	input  wire logic        i_low_power_request_n,
	input  wire logic [2:0]  i_trip_level_pin,
	input  wire logic [2:0]  i_load_check_select,
	input  wire logic        i_trip_cmp,
	input  wire logic        i_slewing,
	input  wire logic        i_ocp_det,
	input  wire logic        i_tsd_det,
	input  wire logic        i_ola_det,
	input  wire logic        i_passive_check_comparator,
	input  wire logic        i_error_pin_low_in,
	output logic             o_out1_high,
	output logic             o_out2_high,
	output logic             o_bridge_on,
	output logic [2:0]       o_trip_reference_code,
	output logic             o_passive_check_en,
	output logic             o_active_detect_en,
	output logic             o_retry_reaction,
	output logic             o_off_time_active,
	output logic             o_error_pin_low_out,
	output logic             o_error_pin_low_oe_n
);

	// Strap level to trip code; unused levels read as regulation off.
	function automatic logic [2:0] lvl_to_trip(input logic [2:0] lvl);
		logic [2:0] code;
		code = bct_pkg::TRIP_OFF;
		unique case (lvl)
			bct_pkg::LVL2: code = bct_pkg::TRIP_L1;
			bct_pkg::LVL3: code = bct_pkg::TRIP_L3;
			bct_pkg::LVL4: code = bct_pkg::TRIP_L4;
			bct_pkg::LVL5: code = bct_pkg::TRIP_L5;
			bct_pkg::LVL6: code = bct_pkg::TRIP_L6;
			default:       code = bct_pkg::TRIP_OFF;
		endcase
		return code;
	endfunction : lvl_to_trip

	// Strapped load check decode for both bridge modes.
	function automatic bct_pkg::bct_load_cfg_t strap_load(
		input logic [2:0] lvl, input logic indep);
		bct_pkg::bct_load_cfg_t c;
		c.high_side  = indep && (lvl == bct_pkg::LVL3 || lvl == bct_pkg::LVL4);
		c.passive_en = !(lvl == bct_pkg::LVL1 || lvl == bct_pkg::LVL5);
		c.latch      = indep ? !(lvl == bct_pkg::LVL1 ||
			lvl == bct_pkg::LVL4 || lvl == bct_pkg::LVL6) :
			(lvl != bct_pkg::LVL1);
		return c;
	endfunction : strap_load

	logic [bct_pkg::ANA_N-1:0] ana_raw;
	logic [bct_pkg::ANA_N-1:0] sync1_q;
	logic [bct_pkg::ANA_N-1:0] sync2_q;
	logic [bct_pkg::CFG_W-1:0] cfg_q;
	logic [2:0]                load_pin_q;
	logic                      init_q;
	bct_pkg::bct_state_t       st_q;
	bct_pkg::bct_state_t       st_d;
	logic [bct_pkg::CNT_W-1:0] cnt_q;
	logic [bct_pkg::CNT_W-1:0] cnt_d;
	logic [bct_pkg::BLK_W-1:0] blank_q;
	logic                      lsr_q;
	logic [2:0]                snap_q;
	logic                      trip_flag_q;
	logic                      ocp_log_q;
	logic                      tsd_log_q;
	logic                      ola_log_q;
	logic                      pin_drive_q;
	logic                      wr_q;
	logic [7:0]                addr_q;
	logic [31:0]               rdata_q;
	bct_pkg::bct_bridge_t      out_q;
	logic [2:0]                trip_ref_q;

	// Comparator inputs gathered for the synchroniser bank.
	assign ana_raw[bct_pkg::ANA_TRIP] = i_trip_cmp;
	assign ana_raw[bct_pkg::ANA_SLEW] = i_slewing;
	assign ana_raw[bct_pkg::ANA_OCP]  = i_ocp_det;
	assign ana_raw[bct_pkg::ANA_TSD]  = i_tsd_det;
	assign ana_raw[bct_pkg::ANA_OLA]  = i_ola_det;
	assign ana_raw[bct_pkg::ANA_PCMP] = i_passive_check_comparator;

	// Two-stage synchronisers
	// Only the second stage is read, so a metastable first stage never leaks.
	for (genvar g = 0; g < bct_pkg::ANA_N; g++) begin : g_sync
		always_ff @(posedge i_core_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				sync1_q[g] <= 1'b0;
				sync2_q[g] <= 1'b0;
			end else begin
				sync1_q[g] <= ana_raw[g];
				sync2_q[g] <= sync1_q[g];
			end
		end
	end

	wire trip_s = sync2_q[bct_pkg::ANA_TRIP];
	wire slew_s = sync2_q[bct_pkg::ANA_SLEW];
	wire ocp_s  = sync2_q[bct_pkg::ANA_OCP];
	wire tsd_s  = sync2_q[bct_pkg::ANA_TSD];
	wire ola_s  = sync2_q[bct_pkg::ANA_OLA];
	wire pcmp_s = sync2_q[bct_pkg::ANA_PCMP];

	// Power states taken from the sleep and disable pins.
	wire awake        = i_low_power_request_n;
	wire active_state = awake && !i_driver_disable_pin && !init_q;
	wire standby      = awake && i_driver_disable_pin && !init_q;

	// Bus decode; the slave never stalls and always answers OKAY.
	wire        acc     = i_hsel && i_hready && i_htrans[1];
	wire [7:0]  acc_ofs = i_haddr[7:0];
	wire        hi_zero = (i_haddr[31:8] == 24'h000000);
	wire        wr_cfg  = wr_q && addr_q == bct_pkg::OFS_CONFIG && awake;
	wire        wr_cmd  = wr_q && addr_q == bct_pkg::OFS_COMMAND;
	wire        clr_cmd = wr_cmd && i_hwdata[bct_pkg::CMD_CLEAR_BIT];

	// Register fields.
	wire [2:0] cfg_trip = cfg_q[bct_pkg::CFG_TRIP_LSB +: 3];
	wire [1:0] cfg_load = cfg_q[bct_pkg::CFG_LOAD_LSB +: 2];
	wire [1:0] cfg_regulation_off_time = cfg_q[bct_pkg::CFG_REGULATION_OFF_TIME_LSB +: 2];
	wire       cfg_lock = cfg_q[bct_pkg::CFG_LOCK_BIT];

	// Trip code select
	// The strap is read live; the register takes effect the cycle after.
	wire [2:0] trip_code = i_reg_variant ? cfg_trip :
		lvl_to_trip(i_trip_level_pin);

	// Load check decode
	// The register decode fixes latch reaction since no field selects it.
	bct_pkg::bct_load_cfg_t reg_load;
	bct_pkg::bct_load_cfg_t ld;
	assign reg_load.high_side  = i_indep_mode && cfg_load[1];
	assign reg_load.passive_en = i_indep_mode ? cfg_load[0] : (|cfg_load);
	assign reg_load.latch      = 1'b1;
	assign ld = i_reg_variant ? reg_load : strap_load(load_pin_q, i_indep_mode);

	wire reg_en   = (trip_code != bct_pkg::TRIP_OFF) && !ld.high_side;
	// Open-load mask for low-side loads in independent mode.
	wire ola_mask = i_indep_mode && !ld.high_side;

	// Commanded bridge from the user pins.
	bct_pkg::bct_bridge_t cmd;
	assign cmd.on   = awake && !i_driver_disable_pin && !init_q;
	assign cmd.out1 = i_indep_mode ? i_in1 : (i_in1 && i_in2);
	assign cmd.out2 = i_indep_mode ? i_in2 : (i_in1 && !i_in2);
	wire lsr_now   = cmd.on && !cmd.out1 && !cmd.out2;
	wire hs_on     = cmd.on && (cmd.out1 || cmd.out2);
	wire leave_lsr = lsr_q && !lsr_now;
	wire blank_ok  = (blank_q == '0) && !leave_lsr;

	wire trip_valid = trip_s && !slew_s && blank_ok && hs_on && reg_en &&
		active_state;

	// Off-time length
	// Field steps are 20, 30, 40 and 50 us.
	wire [bct_pkg::CNT_W-1:0] regulation_off_time_len = i_reg_variant ?
		bct_pkg::CNT_W'((bct_pkg::REGULATION_OFF_TIME_BASE_US +
		bct_pkg::REGULATION_OFF_TIME_STEP_US * int'(cfg_regulation_off_time)) * CYC_PER_US) :
		bct_pkg::CNT_W'(bct_pkg::REGULATION_OFF_TIME_PIN_US * CYC_PER_US);

	wire [2:0] inputs_now = {i_driver_disable_pin, i_in1, i_in2};
	wire       inputs_chg = (snap_q != inputs_now);
	wire       off_end    = (cnt_q == bct_pkg::CNT_W'(1));

	// Off-time sequencer; inputs always win over the internal timer.
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			bct_pkg::ST_DRIVE: begin
				if (trip_valid) begin
					st_d  = bct_pkg::ST_OFF;
					cnt_d = regulation_off_time_len;
				end
			end
			bct_pkg::ST_OFF: begin
				if (inputs_chg || !cmd.on || !reg_en) begin
					st_d  = bct_pkg::ST_DRIVE;
					cnt_d = '0;
				end else if (off_end && trip_s) begin
					cnt_d = regulation_off_time_len;
				end else if (off_end) begin
					st_d  = bct_pkg::ST_DRIVE;
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q - bct_pkg::CNT_W'(1);
				end
			end
		endcase
	end

	// Output override during off-time
	// Full bridge recirculates high; independent drops high outputs low.
	bct_pkg::bct_bridge_t drv;
	wire in_off = (st_q == bct_pkg::ST_OFF);
	assign drv.on   = cmd.on;
	assign drv.out1 = in_off ? !i_indep_mode : cmd.out1;
	assign drv.out2 = in_off ? !i_indep_mode : cmd.out2;

	// Regulation state, blanking and bridge output flops.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q    <= bct_pkg::ST_DRIVE;
			cnt_q   <= '0;
			snap_q  <= '0;
			lsr_q   <= 1'b0;
			blank_q <= '0;
			out_q   <= '0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			lsr_q  <= lsr_now;
			out_q  <= drv;
			if (st_q == bct_pkg::ST_DRIVE)
				snap_q <= inputs_now;
			if (leave_lsr)
				blank_q <= bct_pkg::BLK_W'(bct_pkg::BLANK_CYC);
			else if (blank_q != '0)
				blank_q <= blank_q - bct_pkg::BLK_W'(1);
		end
	end

	// Load check strap capture
	// Caught once after reset or wake; later pin changes are ignored.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			init_q     <= 1'b1;
			load_pin_q <= '0;
		end else if (!awake) begin
			init_q <= 1'b1;
		end else if (init_q) begin
			init_q     <= 1'b0;
			load_pin_q <= i_load_check_select;
		end
	end

	// Error logging
	// Sleep or the clear command empties the logs, but a new event wins.
	wire clr_any = clr_cmd || !awake;
	wire ev_ocp  = ocp_s && active_state;
	wire ev_tsd  = tsd_s && awake;
	wire ev_ola  = ola_s && active_state && !ola_mask;
	// Trip flag only exists in the register variant.
	wire ev_trip = trip_valid && i_reg_variant;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trip_flag_q <= 1'b0;
			ocp_log_q   <= 1'b0;
			tsd_log_q   <= 1'b0;
			ola_log_q   <= 1'b0;
		end else begin
			trip_flag_q <= ev_trip || (trip_flag_q && !clr_any);
			ocp_log_q   <= ev_ocp || (ocp_log_q && !clr_any);
			tsd_log_q   <= ev_tsd || (tsd_log_q && !clr_any);
			ola_log_q   <= ev_ola || (ola_log_q && !clr_any);
		end
	end

	// Summary excludes the trip flag, which never reaches the pin.
	wire summary    = ocp_log_q || tsd_log_q || ola_log_q;
	wire live_fault = ev_ocp || ev_tsd || ev_ola;

	// Error pin drive
	// The passive comparator owns the pin when the override applies.
	wire pcmp_on_pin = ld.passive_en && standby &&
		(!i_reg_variant || cfg_lock);
	wire pin_d = !awake ? 1'b0 :
		pcmp_on_pin ? !pcmp_s :
		(i_reg_variant || ld.latch) ? summary : live_fault;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_drive_q <= 1'b0;
			trip_ref_q  <= '0;
		end else begin
			pin_drive_q <= pin_d;
			trip_ref_q  <= reg_en ? trip_code : bct_pkg::TRIP_OFF;
		end
	end

	// Status words
	// Each fault has its own bit, so one read tells all.
	wire [31:0] act_word = 32'(
		{tsd_log_q, ola_log_q, ocp_log_q, trip_flag_q});
	wire [31:0] sby_word = 32'({summary, tsd_log_q, pcmp_s});
	wire [31:0] st_word  = 32'({i_error_pin_low_in, init_q, ld.latch,
		ld.passive_en, ld.high_side, in_off, trip_code});

	// Read mux, registered in the address phase; unmapped reads zero.
	wire [31:0] rd_mux =
		!hi_zero ? 32'h00000000 :
		acc_ofs == bct_pkg::OFS_CONFIG  ? 32'(cfg_q) :
		acc_ofs == bct_pkg::OFS_SUMMARY ? 32'(summary) :
		acc_ofs == bct_pkg::OFS_ACTIVE  ? act_word :
		acc_ofs == bct_pkg::OFS_STANDBY ? sby_word :
		acc_ofs == bct_pkg::OFS_STATE   ? st_word : 32'h00000000;

	// Bus phase tracking and configuration write.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q    <= 1'b0;
			addr_q  <= '0;
			rdata_q <= '0;
			cfg_q   <= bct_pkg::CFG_RESET;
		end else begin
			wr_q   <= acc && i_hwrite && hi_zero;
			addr_q <= acc_ofs;
			if (acc && !i_hwrite)
				rdata_q <= rd_mux;
			if (wr_cfg)
				cfg_q <= i_hwdata[bct_pkg::CFG_W-1:0];
		end
	end

	// Output assignments.
	assign o_hreadyout           = 1'b1;
	assign o_hresp               = 1'b0;
	assign o_hrdata              = rdata_q;
	assign o_out1_high           = out_q.out1;
	assign o_out2_high           = out_q.out2;
	assign o_bridge_on           = out_q.on;
	assign o_trip_reference_code = trip_ref_q;
	assign o_passive_check_en    = ld.passive_en;
	assign o_active_detect_en    = !ola_mask;
	assign o_retry_reaction      = !ld.latch;
	assign o_off_time_active     = in_off;
	assign o_error_pin_low_out   = 1'b0;
	assign o_error_pin_low_oe_n  = !pin_drive_q;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_off_and_change;
		in_off && inputs_chg;
	endsequence

	sequence s_off_expire_tripped;
		in_off && off_end && trip_s && !inputs_chg && cmd.on && reg_en;
	endsequence

	a_input_precedence: assert property (
		s_off_and_change |=> !in_off ##1 (!o_off_time_active ||
		$past(trip_valid))) else $error("off-time survived an input change");
	a_slew_blocks_trip: assert property (
		(!in_off && slew_s) |=> !in_off)
		else $error("off-time started during slewing");
	a_blank_after_lsr: assert property (
		(leave_lsr && !in_off) |=> (!in_off)[*8])
		else $error("trip accepted inside blanking");
	a_disabled_code: assert property (
		(trip_code == bct_pkg::TRIP_OFF) |=>
		o_trip_reference_code == bct_pkg::TRIP_OFF)
		else $error("regulation reference set for disabled code");
	a_trip_flag_hold: assert property (
		(trip_flag_q && !clr_cmd && awake) |=> trip_flag_q)
		else $error("trip flag lost without clear");
	a_high_side_mask: assert property (
		(ld.high_side && !in_off) |=> !in_off)
		else $error("regulation ran with a high-side load");
	a_strap_frozen: assert property (
		(!init_q && awake) |=> $stable(load_pin_q))
		else $error("load check strap changed after init");
	a_sleep_release: assert property (
		!awake |=> o_error_pin_low_oe_n)
		else $error("error pin driven in sleep");
	a_summary_pin: assert property (
		(i_reg_variant && awake && !pcmp_on_pin && summary) |=>
		!o_error_pin_low_oe_n) else $error("error pin not following summary");
	a_off_extend: assert property (
		s_off_expire_tripped |=> in_off && cnt_q == $past(regulation_off_time_len))
		else $error("off-time not extended while tripped");
	a_fb_recirc: assert property (
		(in_off && !i_indep_mode) |=> o_out1_high && o_out2_high)
		else $error("full bridge not recirculating high");
	a_indep_drop: assert property (
		(in_off && i_indep_mode) |=> !o_out1_high && !o_out2_high)
		else $error("independent output not dropped in off-time");

endmodule : bct_ctrl

`default_nettype wire

//--- hdl/bct_pkg.sv
// Constants, register map and carrier types of the bridge current trip,
// load check and error signalling control block.
// Assumes a single 100 MHz core clock and a 32-bit AHB-Lite register bus.
`default_nettype none

package bct_pkg;

	// Core clock rate and the fixed timing figures.
	localparam int CLK_FREQ_MHZ   = 100;
	localparam int CYC_PER_US_DEF = CLK_FREQ_MHZ;
	localparam int REGULATION_OFF_TIME_PIN_US    = 30;
	localparam int REGULATION_OFF_TIME_BASE_US   = 20;
	localparam int REGULATION_OFF_TIME_STEP_US   = 10;
	localparam int BLANK_NS       = 1000;
	localparam int BLANK_CYC      = (BLANK_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int CNT_W          = 16;
	localparam int BLK_W          = 8;

	// Register byte offsets.
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_COMMAND = 8'h04;
	localparam logic [7:0] OFS_SUMMARY = 8'h08;
	localparam logic [7:0] OFS_ACTIVE  = 8'h0C;
	localparam logic [7:0] OFS_STANDBY = 8'h10;
	localparam logic [7:0] OFS_STATE   = 8'h14;

	// Configuration register fields.
	localparam int CFG_TRIP_LSB = 0;
	localparam int CFG_LOAD_LSB = 3;
	localparam int CFG_REGULATION_OFF_TIME_LSB = 5;
	localparam int CFG_LOCK_BIT = 7;
	localparam int CFG_W        = 8;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

	// Command register: writing one here clears the logged errors.
	localparam int CMD_CLEAR_BIT = 0;

	// Active-state status bits.
	localparam int ACT_TRIP_BIT = 0;
	localparam int ACT_OCP_BIT  = 1;
	localparam int ACT_OLA_BIT  = 2;
	localparam int ACT_TSD_BIT  = 3;

	// Standby-state status bits.
	localparam int SBY_CMP_BIT  = 0;
	localparam int SBY_TSD_BIT  = 1;
	localparam int SBY_ERR_BIT  = 2;

	// Trip level codes as the three-bit field holds them.
	localparam logic [2:0] TRIP_OFF   = 3'h0;
	localparam logic [2:0] TRIP_L1    = 3'h1;
	localparam logic [2:0] TRIP_L3    = 3'h4;
	localparam logic [2:0] TRIP_L4    = 3'h5;
	localparam logic [2:0] TRIP_L5    = 3'h6;
	localparam logic [2:0] TRIP_L6    = 3'h7;

	// Strap levels of the six-level pins, numbered one to six.
	localparam logic [2:0] LVL1 = 3'h1;
	localparam logic [2:0] LVL2 = 3'h2;
	localparam logic [2:0] LVL3 = 3'h3;
	localparam logic [2:0] LVL4 = 3'h4;
	localparam logic [2:0] LVL5 = 3'h5;
	localparam logic [2:0] LVL6 = 3'h6;

	// Analog comparator inputs that pass through synchronisers.
	localparam int ANA_N    = 6;
	localparam int ANA_TRIP = 0;
	localparam int ANA_SLEW = 1;
	localparam int ANA_OCP  = 2;
	localparam int ANA_TSD  = 3;
	localparam int ANA_OLA  = 4;
	localparam int ANA_PCMP = 5;

	// Decoded load check setting.
	typedef struct packed {
		logic high_side;
		logic passive_en;
		logic latch;
	} bct_load_cfg_t;

	// Commanded bridge state.
	typedef struct packed {
		logic on;
		logic out1;
		logic out2;
	} bct_bridge_t;

	typedef enum logic {
		ST_DRIVE,
		ST_OFF
	} bct_state_t;

endpackage : bct_pkg

`default_nettype wire
